// File: design/pxs_pkg.sv
// pxs_pkg: constants, register map and state types of the sequencer core.
// assumes a 40 MHz reference clock.
package pxs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 40;
    localparam int STEP_NS      = 2720000; // start delay, wait step, wait delay
    localparam int CONV_NS      = 2730000; // one conversion time unit
    localparam int LED_ON_NS    = 7300;
    localparam int PULSE_PER_NS = 16000;
    localparam int LONG_MULT    = 12;
    localparam int STEP_CYC_NOM = STEP_NS * CLK_MHZ / 1000;
    localparam int CONV_CYC_NOM = CONV_NS * CLK_MHZ / 1000;
    localparam int LED_ON_CYC   = LED_ON_NS * CLK_MHZ / 1000;
    localparam int PULSE_CYC    = PULSE_PER_NS * CLK_MHZ / 1000;
    localparam int TMR_W        = 21;

    // ------------------------------------------------------------
    // serial target and register map
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR     = 7'h39;
    localparam logic [7:0] DEV_ID       = 8'h5A; // arbitrary value
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam int         CMD_BIT      = 7;
    localparam logic [1:0] TYPE_AUTO    = 2'h1;
    localparam logic [1:0] TYPE_SPECIAL = 2'h3;
    localparam logic [4:0] SF_INT_CLR   = 5'h05;
    localparam logic [4:0] REG_ENABLE   = 5'h00;
    localparam logic [4:0] REG_CONV     = 5'h02;
    localparam logic [4:0] REG_WAIT     = 5'h03;
    localparam logic [4:0] REG_LO_L     = 5'h08;
    localparam logic [4:0] REG_LO_H     = 5'h09;
    localparam logic [4:0] REG_HI_L     = 5'h0A;
    localparam logic [4:0] REG_HI_H     = 5'h0B;
    localparam logic [4:0] REG_PERSIST  = 5'h0C;
    localparam logic [4:0] REG_CONFIG   = 5'h0D;
    localparam logic [4:0] REG_PULSES   = 5'h0E;
    localparam logic [4:0] REG_CONTROL  = 5'h0F;
    localparam logic [4:0] REG_ID       = 5'h12;
    localparam logic [4:0] REG_STATUS   = 5'h13;
    localparam logic [4:0] REG_RES_L    = 5'h18;
    localparam logic [4:0] REG_RES_H    = 5'h19;
    localparam logic [7:0] CONV_RST     = 8'hFF;
    localparam logic [7:0] WAIT_RST     = 8'hFF;
    localparam logic [7:0] EN_WMASK     = 8'h2F;
    localparam logic [7:0] PERS_WMASK   = 8'hF0;
    localparam logic [7:0] CFG_WMASK    = 8'h02;
    localparam logic [7:0] CTRL_WMASK   = 8'hF0;

    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int EN_PON = 0;
    localparam int EN_SE_LO = 1;
    localparam int EN_SE_HI = 2;
    localparam int EN_WEN = 3;
    localparam int EN_IEN = 5;
    localparam int CFG_LONG = 1;
    localparam int PERS_HI = 7;
    localparam int PERS_LO = 4;
    localparam int DRV_HI = 7;
    localparam int DRV_LO = 6;
    localparam int DIO_HI = 5;
    localparam int DIO_LO = 4;
    localparam int STAT_VALID = 0;
    localparam int STAT_PINT = 5;
    localparam logic [1:0] DIO_NONE = 2'h0;
    localparam logic [1:0] DIO_B    = 2'h2;
    localparam logic [8:0] SPAN     = 9'h100;
    localparam logic [3:0] PCNT_MAX = 4'hF;

    typedef enum logic [2:0] {
        S_SLEEP = 3'h0, S_SDLY = 3'h1, S_START = 3'h2, S_ACCUM = 3'h3,
        S_CONV  = 3'h4, S_WCHK = 3'h5, S_WAIT  = 3'h6, S_WDLY  = 3'h7
    } pxs_seq_t;

    typedef enum logic [2:0] {
        I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h2, I_WR = 3'h3,
        I_WACK = 3'h4, I_RD   = 3'h5, I_RACK = 3'h6
    } pxs_ser_t;

endpackage : pxs_pkg

// File: design/pxs_core.sv
// pxs_core: proximity sensor sequencer with two-wire serial register target.
// assumes scl/sda are sampled by link_clk (much faster than scl) and that
// the analog front end presents per-pulse counts on ref_clk.
`timescale 1ns/1ps

// Functional notes
// [R01] after reset sleep until power bit set
// [R02] power on waits start delay before start
// [R03] power off lets conversion finish, then sleep
// [R04] start, accumulate, convert, then wait-check
// [R05] wait state runs only when enabled
// [R06] long wait makes each step twelve times
// [R07] wait end adds fixed delay before start
// [R08] wait steps of 2.72 ms, 1 to 256
// [R09] two-bit drive strength scales LED current
// [R10] LED pulse 7.3 us on, 16 us period
// [R11] pulses per accumulate equal programmed count
// [R12] no diode selected means no result
// [R13] 16-bit result stored as two bytes
// [R14] conversion time scales result, 1 to 256
// [R15] software should keep conversion time default
// [R16] interrupts only while interrupt enable set
// [R17] out of range above upper, below lower
// [R18] interrupt after persistence consecutive out cycles
// [R19] serial target with 7-bit address
// [R20] host sends command byte first in writes
// [R21] read uses last selected register address
// [R22] first byte msb clear is data
// [R23] interrupt level holds until software clears
// [R24] host sets command bit in command bytes
// [R25] special function 00101 clears pending interrupt
// [R26] persistence zero fires every cycle
// [R27] both result bytes update together
module pxs_core
    import pxs_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYC_NOM,
    parameter int CONV_CYC = CONV_CYC_NOM
)(
    // system
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // serial link
    input  wire logic       link_clk,
    input  wire logic       scl,
    input  wire logic       sda_pin,
    output logic            sda_drv,
    output logic            sda_oe,
    // interrupt pin, open drain
    output logic            int_drv,
    output logic            int_oe,
    // analog front end
    input  wire logic [9:0] photodiode_a,
    input  wire logic [9:0] photodiode_b,
    output logic            led_sink_pin,
    output logic [1:0]      led_drive_strength
);

    localparam logic [TMR_W-1:0] STEP_LIM = TMR_W'(STEP_CYC - 1);
    localparam logic [TMR_W-1:0] LONG_LIM = TMR_W'(STEP_CYC*LONG_MULT - 1);
    localparam logic [TMR_W-1:0] CONV_LIM = TMR_W'(CONV_CYC - 1);
    localparam logic [TMR_W-1:0] PER_LIM  = TMR_W'(PULSE_CYC - 1);
    localparam logic [TMR_W-1:0] ON_LIM   = TMR_W'(LED_ON_CYC);

    // ------------------------------------------------------------
    // link domain: reset and pin synchronisers
    // ------------------------------------------------------------
    logic       lr1_q, link_rst;
    logic [2:0] scl_q, sda_q, stt_q;
    logic       stat_tgl_q;

    always_ff @(posedge link_clk)
    begin
        lr1_q    <= srst;
        link_rst <= lr1_q;
        scl_q    <= {scl_q[1:0], scl};
        sda_q    <= {sda_q[1:0], sda_pin};
        stt_q    <= {stt_q[1:0], stat_tgl_q};
    end

    wire rise  = scl_q[1] & ~scl_q[2];
    wire fall  = ~scl_q[1] & scl_q[2];
    wire start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    wire stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    wire stat_evt = stt_q[1] ^ stt_q[2];

    // ------------------------------------------------------------
    // link domain: serial target and register file
    // ------------------------------------------------------------
    pxs_ser_t    ist_q, ist_d;
    logic [2:0]  bcnt_q, bcnt_d;
    logic [7:0]  sh_q, sh_d, tx_q, tx_d, rdb, rx;
    logic        rw_q, rw_d, first_q, first_d, oe_q, oe_d;
    logic [1:0]  type_q, type_d;
    logic [4:0]  ptr_q, ptr_d;
    logic [7:0]  en_q, en_d, ct_q, ct_d, ws_q, ws_d, pp_q, pp_d;
    logic [7:0]  ps_q, ps_d, cf_q, cf_d, cr_q, cr_d;
    logic [15:0] lo_q, lo_d, hi_q, hi_d, rl_q, rl_d;
    logic        cfg_tgl_q, cfg_tgl_d, clr_tgl_q, clr_tgl_d;
    logic        pl_q, pl_d, vl_q, vl_d;
    logic [15:0] res_q;
    logic        pint_q, valid_q;

    always_comb
    begin
        unique case (ptr_q) // [R21]
            REG_ENABLE:  rdb = en_q;
            REG_CONV:    rdb = ct_q;
            REG_WAIT:    rdb = ws_q;
            REG_LO_L:    rdb = lo_q[7:0];
            REG_LO_H:    rdb = lo_q[15:8];
            REG_HI_L:    rdb = hi_q[7:0];
            REG_HI_H:    rdb = hi_q[15:8];
            REG_PERSIST: rdb = ps_q;
            REG_CONFIG:  rdb = cf_q;
            REG_PULSES:  rdb = pp_q;
            REG_CONTROL: rdb = cr_q;
            REG_ID:      rdb = DEV_ID;
            REG_STATUS:  rdb = 8'((pl_q << STAT_PINT) | (vl_q << STAT_VALID));
            REG_RES_L:   rdb = rl_q[7:0];
            REG_RES_H:   rdb = rl_q[15:8];
            default:     rdb = 8'h00;
        endcase
    end

    always_comb
    begin
        ist_d = ist_q; bcnt_d = bcnt_q; sh_d = sh_q; tx_d = tx_q;
        rw_d = rw_q; first_d = first_q; oe_d = oe_q; type_d = type_q;
        ptr_d = ptr_q; en_d = en_q; ct_d = ct_q; ws_d = ws_q; pp_d = pp_q;
        ps_d = ps_q; cf_d = cf_q; cr_d = cr_q; lo_d = lo_q; hi_d = hi_q;
        cfg_tgl_d = cfg_tgl_q; clr_tgl_d = clr_tgl_q;
        rl_d = stat_evt ? res_q : rl_q; // both bytes at once [R27]
        pl_d = stat_evt ? pint_q : pl_q;
        vl_d = stat_evt ? valid_q : vl_q;
        rx = {sh_q[6:0], sda_q[2]};
        if (start)
        begin
            ist_d = I_ADDR; bcnt_d = 3'h0; oe_d = 1'b0;
        end
        else if (stop)
        begin
            ist_d = I_IDLE; oe_d = 1'b0;
        end
        else unique case (ist_q)
            I_IDLE: ;
            I_ADDR: if (rise)
            begin
                sh_d = rx; bcnt_d = bcnt_q + 3'h1;
                if (bcnt_q == BIT_LAST)
                begin
                    rw_d = rx[0]; first_d = 1'b1;
                    ist_d = (rx[7:1] == DEV_ADDR) ? I_AACK : I_IDLE; // [R19]
                end
            end
            I_AACK: if (fall)
            begin
                if (!oe_q) oe_d = 1'b1;
                else if (rw_q)
                begin
                    oe_d = ~rdb[7]; tx_d = {rdb[6:0], 1'b0}; ist_d = I_RD;
                end
                else
                begin
                    oe_d = 1'b0; ist_d = I_WR;
                end
            end
            I_WR: if (rise)
            begin
                sh_d = rx; bcnt_d = bcnt_q + 3'h1;
                if (bcnt_q == BIT_LAST)
                begin
                    ist_d = I_WACK; first_d = 1'b0;
                    if (first_q && rx[CMD_BIT])
                    begin
                        type_d = rx[6:5];
                        if (rx[6:5] != TYPE_SPECIAL) ptr_d = rx[4:0];
                        else if (rx[4:0] == SF_INT_CLR)
                            clr_tgl_d = ~clr_tgl_q; // [R25]
                    end
                    else
                    begin // data at held address [R22]
                        cfg_tgl_d = ~cfg_tgl_q;
                        if (type_q == TYPE_AUTO) ptr_d = ptr_q + 5'h01;
                        case (ptr_q)
                            REG_ENABLE:  en_d = rx & EN_WMASK;
                            REG_CONV:    ct_d = rx;
                            REG_WAIT:    ws_d = rx;
                            REG_LO_L:    lo_d[7:0] = rx;
                            REG_LO_H:    lo_d[15:8] = rx;
                            REG_HI_L:    hi_d[7:0] = rx;
                            REG_HI_H:    hi_d[15:8] = rx;
                            REG_PERSIST: ps_d = rx & PERS_WMASK;
                            REG_CONFIG:  cf_d = rx & CFG_WMASK;
                            REG_PULSES:  pp_d = rx;
                            REG_CONTROL: cr_d = rx & CTRL_WMASK;
                            default: ;
                        endcase
                    end
                end
            end
            I_WACK: if (fall)
            begin
                oe_d = ~oe_q;
                if (oe_q) ist_d = I_WR;
            end
            I_RD: if (fall)
            begin
                if (bcnt_q == BIT_LAST)
                begin
                    oe_d = 1'b0; ist_d = I_RACK;
                    if (type_q == TYPE_AUTO) ptr_d = ptr_q + 5'h01;
                end
                else
                begin
                    oe_d = ~tx_q[7]; tx_d = {tx_q[6:0], 1'b0};
                    bcnt_d = bcnt_q + 3'h1;
                end
            end
            I_RACK: if (rise && sda_q[2]) ist_d = I_IDLE;
            else if (fall)
            begin
                oe_d = ~rdb[7]; tx_d = {rdb[6:0], 1'b0};
                bcnt_d = 3'h0; ist_d = I_RD;
            end
            default: ist_d = I_IDLE;
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            ist_q <= I_IDLE; bcnt_q <= 3'h0; sh_q <= 8'h00; tx_q <= 8'h00;
            rw_q <= 1'b0; first_q <= 1'b0; oe_q <= 1'b0; type_q <= 2'h0;
            ptr_q <= 5'h00; en_q <= 8'h00; ct_q <= CONV_RST;
            ws_q <= WAIT_RST; pp_q <= 8'h00; ps_q <= 8'h00; cf_q <= 8'h00;
            cr_q <= 8'h00; lo_q <= 16'h0000; hi_q <= 16'h0000;
            cfg_tgl_q <= 1'b0; clr_tgl_q <= 1'b0;
            rl_q <= 16'h0000; pl_q <= 1'b0; vl_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d; bcnt_q <= bcnt_d; sh_q <= sh_d; tx_q <= tx_d;
            rw_q <= rw_d; first_q <= first_d; oe_q <= oe_d; type_q <= type_d;
            ptr_q <= ptr_d; en_q <= en_d; ct_q <= ct_d; ws_q <= ws_d;
            pp_q <= pp_d; ps_q <= ps_d; cf_q <= cf_d; cr_q <= cr_d;
            lo_q <= lo_d; hi_q <= hi_d;
            cfg_tgl_q <= cfg_tgl_d; clr_tgl_q <= clr_tgl_d;
            rl_q <= rl_d; pl_q <= pl_d; vl_q <= vl_d;
        end
    end

    assign sda_oe  = oe_q;
    assign sda_drv = 1'b0;

    // ------------------------------------------------------------
    // reference domain: toggle crossings from the link
    // ------------------------------------------------------------
    // config words are copied on a toggle edge; a serial byte lasts far
    // longer than the three-flop path, so the source is stable by then
    logic [2:0] cft_q, clt_q;

    always_ff @(posedge ref_clk)
    begin
        cft_q <= {cft_q[1:0], cfg_tgl_q};
        clt_q <= {clt_q[1:0], clr_tgl_q};
    end

    wire cfg_evt = cft_q[1] ^ cft_q[2];
    wire clr_evt = clt_q[1] ^ clt_q[2];

    // ------------------------------------------------------------
    // reference domain: sequencer, LED pulser, filter
    // ------------------------------------------------------------
    pxs_seq_t         st_q, st_d;
    logic [TMR_W-1:0] tmr_q, tmr_d, wlim;
    logic [8:0]       ucnt_q, ucnt_d, wsteps, csteps;
    logic [17:0]      acc_q, acc_d;
    logic [26:0]      prod;
    logic [15:0]      res_d, sat;
    logic [3:0]       pcnt_q, pcnt_d, pc_next;
    logic [7:0]       c_en_q, c_ct_q, c_ws_q, c_pp_q, c_ps_q, c_cf_q, c_cr_q;
    logic [15:0]      c_lo_q, c_hi_q;
    logic             valid_d, pint_d, led_q, led_d, stat_tgl_d;
    logic [1:0]       drv_q;
    logic             conv_done, out_rng, fire;

    wire       pwr   = c_en_q[EN_PON];
    wire       sense = &c_en_q[EN_SE_HI:EN_SE_LO];
    wire [1:0] dio   = c_cr_q[DIO_HI:DIO_LO];
    wire [3:0] pers  = c_ps_q[PERS_HI:PERS_LO];
    wire [9:0] samp  = (dio == DIO_B) ? photodiode_b : photodiode_a;

    always_comb
    begin
        st_d = st_q; tmr_d = tmr_q + TMR_W'(1); ucnt_d = ucnt_q;
        acc_d = acc_q; conv_done = 1'b0;
        wsteps = SPAN - {1'b0, c_ws_q}; // [R08]
        csteps = SPAN - {1'b0, c_ct_q};
        wlim = c_cf_q[CFG_LONG] ? LONG_LIM : STEP_LIM; // [R06]
        unique case (st_q)
            S_SLEEP: if (pwr) st_d = S_SDLY; // [R01]
            S_SDLY:
                if (!pwr) st_d = S_SLEEP;
                else if (tmr_q == STEP_LIM) st_d = S_START; // [R02]
            S_START:
            begin
                ucnt_d = 9'h000; acc_d = 18'h00000;
                if (!pwr) st_d = S_SLEEP;
                else if (!sense || dio == DIO_NONE) st_d = S_WCHK; // [R12]
                else if (c_pp_q == 8'h00) st_d = S_CONV;
                else st_d = S_ACCUM; // [R04]
            end
            S_ACCUM: if (tmr_q == PER_LIM) // [R10]
            begin
                tmr_d = '0; acc_d = acc_q + 18'(samp);
                ucnt_d = ucnt_q + 9'h001;
                if (ucnt_d == {1'b0, c_pp_q}) // [R11]
                begin
                    st_d = S_CONV; ucnt_d = 9'h000;
                end
            end
            S_CONV: if (tmr_q == CONV_LIM) // [R14]
            begin
                tmr_d = '0; ucnt_d = ucnt_q + 9'h001;
                if (ucnt_d == csteps)
                begin
                    conv_done = 1'b1; st_d = S_WCHK; // [R04]
                end
            end
            S_WCHK:
            begin
                ucnt_d = 9'h000;
                if (!pwr) st_d = S_SLEEP; // [R03]
                else if (c_en_q[EN_WEN]) st_d = S_WAIT; // [R05]
                else st_d = S_START;
            end
            S_WAIT:
                if (!pwr) st_d = S_SLEEP;
                else if (tmr_q == wlim)
                begin
                    tmr_d = '0; ucnt_d = ucnt_q + 9'h001;
                    if (ucnt_d == wsteps) st_d = S_WDLY; // [R08]
                end
            S_WDLY:
                if (!pwr) st_d = S_SLEEP;
                else if (tmr_q == STEP_LIM) st_d = S_START; // [R07]
        endcase
        if (st_d != st_q) tmr_d = '0;

        // result scaled by conversion units, saturated to 16 bits
        prod = 27'(acc_q) * 27'(csteps); // [R14]
        sat = (|prod[26:16]) ? 16'hFFFF : prod[15:0]; // [R13]
        res_d = conv_done ? sat : res_q;
        valid_d = valid_q | conv_done;
        out_rng = (sat > c_hi_q) || (sat < c_lo_q); // [R17]
        pc_next = !out_rng ? 4'h0
                : (pcnt_q == PCNT_MAX) ? PCNT_MAX : pcnt_q + 4'h1;
        pcnt_d = conv_done ? pc_next : pcnt_q;
        fire = conv_done && (pers == 4'h0 || pc_next >= pers); // [R18] [R26]
        // a new event beats a clear arriving in the same cycle
        pint_d = (fire && c_en_q[EN_IEN]) ? 1'b1 // [R16]
               : clr_evt ? 1'b0 : pint_q; // [R23] [R25]
        stat_tgl_d = stat_tgl_q ^ (conv_done | (pint_d != pint_q));
        led_d = (st_d == S_ACCUM) && (tmr_d < ON_LIM); // [R10]
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q <= S_SLEEP; tmr_q <= '0; ucnt_q <= 9'h000;
            acc_q <= 18'h00000; res_q <= 16'h0000; valid_q <= 1'b0;
            pint_q <= 1'b0; pcnt_q <= 4'h0; led_q <= 1'b0; drv_q <= 2'h0;
            stat_tgl_q <= 1'b0;
            c_en_q <= 8'h00; c_ct_q <= CONV_RST; c_ws_q <= WAIT_RST;
            c_pp_q <= 8'h00; c_ps_q <= 8'h00; c_cf_q <= 8'h00;
            c_cr_q <= 8'h00; c_lo_q <= 16'h0000; c_hi_q <= 16'h0000;
        end
        else
        begin
            st_q <= st_d; tmr_q <= tmr_d; ucnt_q <= ucnt_d; acc_q <= acc_d;
            res_q <= res_d; valid_q <= valid_d; pint_q <= pint_d;
            pcnt_q <= pcnt_d; led_q <= led_d; stat_tgl_q <= stat_tgl_d;
            drv_q <= c_cr_q[DRV_HI:DRV_LO]; // [R09]
            if (cfg_evt)
            begin
                c_en_q <= en_q; c_ct_q <= ct_q; c_ws_q <= ws_q;
                c_pp_q <= pp_q; c_ps_q <= ps_q; c_cf_q <= cf_q;
                c_cr_q <= cr_q; c_lo_q <= lo_q; c_hi_q <= hi_q;
            end
        end
    end

    assign led_sink_pin       = led_q;
    assign led_drive_strength = drv_q;
    assign int_oe             = pint_q;
    assign int_drv            = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_dly_exit;
        st_q == S_SDLY ##1 st_q == S_START;
    endsequence

    sequence s_accum_exit;
        st_q == S_ACCUM ##1 st_q != S_ACCUM;
    endsequence

    a_sleep_hold: assert property (@(posedge ref_clk) disable iff (srst) // [R01]
        st_q == S_SLEEP && !pwr |=> st_q == S_SLEEP)
        else $error("left sleep without power bit");
    a_start_delay: assert property (@(posedge ref_clk) disable iff (srst) // [R02]
        s_dly_exit |-> $past(tmr_q) == STEP_LIM)
        else $error("start delay length wrong");
    a_conv_finish: assert property (@(posedge ref_clk) disable iff (srst) // [R03]
        st_q == S_CONV && !pwr |=> st_q == S_CONV || st_q == S_WCHK)
        else $error("conversion cut short");
    a_accum_next: assert property (@(posedge ref_clk) disable iff (srst) // [R04]
        s_accum_exit |-> st_q == S_CONV && $past(ucnt_q) + 9'h001 ==
            {1'b0, c_pp_q}) // [R11]
        else $error("accumulate exit wrong");
    a_wait_skip: assert property (@(posedge ref_clk) disable iff (srst) // [R05]
        st_q == S_WCHK && pwr && !c_en_q[EN_WEN] |=> st_q == S_START)
        else $error("wait not skipped");
    a_long_step: assert property (@(posedge ref_clk) disable iff (srst) // [R06]
        st_q == S_WAIT && pwr && c_cf_q[CFG_LONG] && tmr_q == STEP_LIM
        |=> st_q == S_WAIT && tmr_q == STEP_LIM + TMR_W'(1))
        else $error("long wait step too short");
    a_led_width: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
        $fell(led_q) && st_q == S_ACCUM |-> tmr_q == ON_LIM)
        else $error("LED on-time wrong");
    a_irq_cause: assert property (@(posedge ref_clk) disable iff (srst) // [R16]
        $rose(pint_q) |-> $past(c_en_q[EN_IEN]) && $past(conv_done))
        else $error("interrupt without enabled conversion");
    a_irq_hold: assert property (@(posedge ref_clk) disable iff (srst) // [R23]
        pint_q && !clr_evt |=> pint_q)
        else $error("interrupt dropped without clear");
    a_res_pair: assert property (@(posedge ref_clk) disable iff (srst) // [R27]
        $changed(res_q) |-> $past(st_q) == S_CONV && st_q == S_WCHK)
        else $error("result changed outside conversion end");

endmodule : pxs_core

// File: sim/pxs_host.sv
// pxs_host: serial bus master model standing in for the host processor.
// assumes the bench resolves the open drain data wire with a pull-up.
`timescale 1ns/1ps
module pxs_host
    import pxs_pkg::*;
(
    // clock and bus
    input  wire logic ref_clk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_low
);
    logic ack;
    logic [7:0] d;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (10) @(posedge ref_clk);
    endtask : q
    // data changes only while scl is low
    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        q();
        scl <= 1'b1;
        q();
        s = sda_w;
        q();
        scl <= 1'b0;
        q();
    endtask : bit_io
    // also serves as repeated start
    task automatic start();
        sda_low <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask : start
    // byte msb first, then ack bit; 8'hFF releases the line to read
    task automatic xfer(input logic [7:0] v, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
        bit_io(1'b1, ack);
    endtask : xfer
    task automatic stop();
        sda_low <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
    endtask : stop
    task automatic wr(input logic [7:0] c, input logic [7:0] v, input bit n);
        start();
        xfer({DEV_ADDR, 1'b0}, d);
        xfer(c, d);
        if (n) xfer(v, d);
        stop();
    endtask : wr
    // command 8'h00 means read at the held pointer
    task automatic rd(input logic [7:0] c, output logic [7:0] r);
        if (c != 8'h00)
        begin
            start();
            xfer({DEV_ADDR, 1'b0}, d);
            xfer(c, d);
        end
        start();
        xfer({DEV_ADDR, 1'b1}, d);
        xfer(8'hFF, r);
        stop();
    endtask : rd
endmodule : pxs_host

// File: sim/tb.sv
// tb: drives the sequencer core through the host model and checks ports.
// assumes short step and conversion counts of 20 cycles.
`timescale 1ns/1ps
module tb;
    import pxs_pkg::*;
    logic ref_clk = 0, link_clk = 0, srst = 1, scl, sda_low, sda_drv, sda_oe;
    logic int_drv, int_oe, led_sink_pin, p;
    logic [9:0] photodiode_a = 10'h010, photodiode_b = 10'h020;
    logic [1:0] led_drive_strength;
    logic [7:0] r;
    wire sda_w = !(sda_low || sda_oe);
    int fail_count = 0, comparisons = 0, n, w;
    always #12.5 ref_clk = !ref_clk;
    always #16 link_clk = !link_clk;
    pxs_core #(.STEP_CYC(20), .CONV_CYC(20)) i_pxs_core (.ref_clk, .srst,
        .link_clk, .scl, .sda_pin(sda_w), .sda_drv, .sda_oe, .int_drv,
        .int_oe, .photodiode_a, .photodiode_b, .led_sink_pin,
        .led_drive_strength);
    pxs_host i_pxs_host (.ref_clk, .sda_w, .scl, .sda_low);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD at %0t: saw %h, wanted %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // bounded: counts led rises and led-high cycles until interrupt
    task automatic watch(input int lim);
        n = 0;
        w = 0;
        p = 1'b0;
        for (int k = 0; k < lim && int_oe !== 1'b1; k++)
        begin
            @(posedge ref_clk);
            #1;
            n += (led_sink_pin === 1'b1 && !p);
            w += (led_sink_pin === 1'b1);
            p = led_sink_pin;
        end
    endtask : watch
    initial
    begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk(int_oe, 1'b0);
        chk({sda_drv, int_drv}, 2'h0);
        i_pxs_host.rd(8'h82, r);
        chk(r, CONV_RST);
        i_pxs_host.rd(8'h92, r);
        chk(r, DEV_ID);
        $display("reset and reads done");
        i_pxs_host.wr(8'hAF, 8'h60, 1);
        chk(i_pxs_host.ack, 1'b0);
        chk(led_drive_strength, 2'h1);
        i_pxs_host.wr(8'hAE, 8'h03, 1);
        // first pulse starts before the enable write has ended
        fork
            i_pxs_host.wr(8'hA0, 8'h27, 1);
            watch(8000);
        join
        chk(n, 3);
        chk(w, 3 * LED_ON_CYC);
        chk(int_oe, 1'b1);
        i_pxs_host.rd(8'hB8, r);
        chk(r, 8'h60);
        i_pxs_host.rd(8'h00, r);
        chk(r, 8'h00);
        chk(int_oe, 1'b1);
        $display("measurement done");
        i_pxs_host.wr(8'h80, 8'h00, 1);
        repeat (3000) @(posedge ref_clk);
        i_pxs_host.wr(8'hE5, 8'h00, 0);
        chk(int_oe, 1'b0);
        watch(3000);
        chk(n, 0);
        // persistence two; zero would fire on every cycle
        i_pxs_host.wr(8'h8C, 8'h20, 1);
        i_pxs_host.wr(8'h8D, 8'h02, 1);
        i_pxs_host.wr(8'h8A, 8'hFF, 1);
        i_pxs_host.wr(8'h80, 8'h2F, 1);
        watch(6000);
        chk(int_oe, 1'b0);
        i_pxs_host.wr(8'h88, 8'h70, 1);
        watch(8000);
        chk(int_oe, 1'b1);
        $display("threshold tests done");
        i_pxs_host.wr(8'h8F, 8'h40, 1);
        repeat (3000) @(posedge ref_clk);
        i_pxs_host.wr(8'hE5, 8'h00, 0);
        watch(3000);
        chk(n, 0);
        chk(int_oe, 1'b0);
        $display("diode select test done");
        stop_test();
    end
endmodule : tb
